/* File: hw/cmcc_pkg.sv */
// Constants, carriers and CRC step functions of the configuration memory CRC checker.
// Assumes the including design runs the checker on one core clock.
package cmcc_pkg;

	localparam int WORD_W = 32;
	localparam int CRC16_W = 16;
	localparam int MEM_DEPTH = 64;
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] ADDR_FIRST = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 6'h3f;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 6'h01;

	localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
	localparam logic [31:0] CRC32_INIT = 32'hffffffff;
	localparam logic [31:0] SIG_ZERO = 32'h00000000;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [15:0] CRC16_INIT = 16'hffff;

	localparam int IR_W = 10;
	localparam logic [IR_W-1:0] INSTR_STORE_OVERWRITE = 10'h015;

	// Oscillator divided by 2^n, n from 0 to 8
	localparam int OSC_FREQ_MHZ = 80;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] DIV_N_MAX = 4'h8;
	localparam int DIVCNT_W = 9;
	localparam logic [DIVCNT_W-1:0] DIVCNT_ONE = 9'h001;

	typedef enum logic [1:0]
	{
		ST_CONFIG = 2'b00,
		ST_USER = 2'b01,
		ST_FAULT = 2'b10
	} cmcc_state_e;

	typedef struct packed
	{
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
		logic frame_end;
		logic [CRC16_W-1:0] frame_crc;
		logic done;
		logic [31:0] final_crc;
	} cmcc_cfg_s;

	typedef struct packed
	{
		logic tck;
		logic tdi;
		logic shift_dr;
		logic [IR_W-1:0] ir;
	} cmcc_jtag_s;

	// One data word into the 32-bit CRC, MSB first
	function automatic logic [31:0] crc32_step(input logic [31:0] crc, input logic [WORD_W-1:0] d);
		logic [31:0] c;
		c = crc;
		for (int i = WORD_W - 1; i >= 0; i--)
		begin
			c = (c[31] ^ d[i]) ? ((c << 1) ^ CRC32_POLY) : (c << 1);
		end
		return c;
	endfunction

	// One data word into the 16-bit frame CRC, MSB first
	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [WORD_W-1:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = WORD_W - 1; i >= 0; i--)
		begin
			c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC16_POLY) : (c << 1);
		end
		return c;
	endfunction

endpackage

/* File: hw/cmcc_sync.sv */
// Two flip-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level; no bus coherence is given.
`timescale 1ns/10ps
module cmcc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule // cmcc_sync

/* File: hw/cmcc_cell_mem.sv */
// Configuration cell memory: one write port, one read port with registered data.
// Assumes writer and reader never use the same cycle on purpose.
`timescale 1ns/10ps
module cmcc_cell_mem (
	input wire logic clk_i,
	input wire logic wr_i,
	input wire logic [cmcc_pkg::ADDR_W-1:0] waddr_i,
	input wire logic [cmcc_pkg::WORD_W-1:0] wdata_i,
	input wire logic rd_i,
	input wire logic [cmcc_pkg::ADDR_W-1:0] raddr_i,
	output logic [cmcc_pkg::WORD_W-1:0] rdata_o
);
	logic [cmcc_pkg::WORD_W-1:0] mem_q [cmcc_pkg::MEM_DEPTH];
	logic [cmcc_pkg::WORD_W-1:0] rdata_q;

	always_ff @(posedge clk_i)
	begin
		if (wr_i)
		begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rd_i)
		begin
			rdata_q <= mem_q[raddr_i];
		end
	end

	assign rdata_o = rdata_q;
endmodule // cmcc_cell_mem

/* File: hw/cmcc_top.sv */
// Configuration memory CRC checker: frame CRC during load, 32-bit background CRC after.
// Assumes a configuration controller on CORE_CLK_I and scan/pin inputs from outside.
//
// Functional notes
// (R1) Failure pin high means corrupted configuration cells were found.
// (R2) Failure pin exists only when enabled; otherwise it is a user I/O.
// (R3) Failure pin is push-pull, never inverted, never open-drain.
// (R4) After an error the checker keeps calculating and drives the pin high.
// (R5) One 32-bit CRC covers the whole cell memory in user mode.
// (R6) Each loaded frame gets a 16-bit CRC computed and compared.
// (R7) Frame CRC mismatch pulls the configuration status line low.
// (R8) Signature register holds compare result; all zeros when clean.
// (R9) Any non-zero signature drives the failure pin high.
// (R10) Storage register loads the precomputed CRC at configuration end.
// (R11) Stored signature feeds the compute-and-compare unit in user mode.
// (R12) Store-overwrite instruction makes the storage register a 32-bit scan chain.
// (R13) Store-overwrite instruction never halts normal user operation.
// (R14) Instruction code 00 0001 0101 puts storage register between scan in and out.
// (R15) Generator is the 32-bit IEEE 802 CRC polynomial.
// (R16) Failure pin holds through the next pass; clears only after a clean pass.
// (R17) Checker rate is the oscillator divided by 2^n, n from 0 to 8.
// (R18) Each pass end updates the signature and starts again at cell zero.
`timescale 1ns/10ps
module cmcc_top (
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	input wire logic ENABLE_I,
	input wire logic [cmcc_pkg::DIV_W-1:0] DIV_N_I,
	input wire cmcc_pkg::cmcc_cfg_s CFG_BUS_I,
	input wire cmcc_pkg::cmcc_jtag_s JTAG_I,
	input wire logic USER_OUT_I,
	input wire logic USER_OE_N_I,
	input wire logic ERR_PIN_I,
	output logic ERR_PIN_O,
	output logic ERR_PIN_OE_N_O,
	output logic USER_IN_O,
	output logic CONFIG_STATUS_LOW_N_O,
	output logic TDO_O,
	output logic USER_MODE_O,
	output logic PASS_DONE_O,
	output logic [31:0] SIGNATURE_O
);
	localparam int JTAG_W = $bits(cmcc_pkg::cmcc_jtag_s);
	localparam int SYNC_W = JTAG_W + cmcc_pkg::DIV_W + 2;

	logic rst_meta_q;
	logic rst_n;
	logic [SYNC_W-1:0] sync_raw;
	cmcc_pkg::cmcc_jtag_s jtag_s;
	logic [cmcc_pkg::DIV_W-1:0] div_n_s;
	logic en_s;
	logic pin_in_s;

	cmcc_pkg::cmcc_state_e state_q;
	cmcc_pkg::cmcc_state_e state_d;
	logic [15:0] crc16_q;
	logic [31:0] crc_q;
	logic [31:0] store_q;
	logic [31:0] signature_q;
	logic fail_q;
	logic status_n_q;
	logic [cmcc_pkg::DIVCNT_W-1:0] div_cnt_q;
	logic [cmcc_pkg::ADDR_W-1:0] scan_addr_q;
	logic rd_pend_q;
	logic last_pend_q;
	logic pass_done_q;
	logic tck_prev_q;
	logic tdo_q;
	logic err_pin_q;
	logic err_oe_n_q;

	wire logic [cmcc_pkg::WORD_W-1:0] rdata;
	wire logic cfg_phase = (state_q == cmcc_pkg::ST_CONFIG);
	wire logic user_phase = (state_q == cmcc_pkg::ST_USER);
	wire logic running = user_phase && en_s; // see (R13)
	wire logic cfg_wr = cfg_phase && CFG_BUS_I.wr;
	wire logic [15:0] crc16_next = cfg_wr ? cmcc_pkg::crc16_step(crc16_q, CFG_BUS_I.data) : crc16_q;
	wire logic frame_check = cfg_phase && CFG_BUS_I.frame_end;
	wire logic frame_bad = frame_check && (crc16_next != CFG_BUS_I.frame_crc);
	wire logic cfg_finish = cfg_phase && CFG_BUS_I.done && !frame_bad;
	wire logic [cmcc_pkg::DIV_W-1:0] div_n_eff =
		(div_n_s > cmcc_pkg::DIV_N_MAX) ? cmcc_pkg::DIV_N_MAX : div_n_s;
	wire logic [cmcc_pkg::DIVCNT_W-1:0] div_limit =
		cmcc_pkg::DIVCNT_W'((cmcc_pkg::DIVCNT_ONE << div_n_eff) - cmcc_pkg::DIVCNT_ONE);
	wire logic tick = running && (div_cnt_q >= div_limit);
	wire logic [31:0] crc_word = cmcc_pkg::crc32_step(crc_q, rdata);
	wire logic [31:0] sig_next = crc_word ^ store_q;
	wire logic tck_rise = jtag_s.tck && !tck_prev_q;
	wire logic instr_active = user_phase && (jtag_s.ir == cmcc_pkg::INSTR_STORE_OVERWRITE);
	wire logic shift_hit = instr_active && jtag_s.shift_dr && tck_rise;

	// Reset release through two flip-flops
	always_ff @(posedge CORE_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	cmcc_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk_i(CORE_CLK_I),
		.rst_n_i(rst_n),
		.d_i({JTAG_I, DIV_N_I, ENABLE_I, ERR_PIN_I}),
		.q_o(sync_raw)
	);

	assign jtag_s = cmcc_pkg::cmcc_jtag_s'(sync_raw[SYNC_W-1 -: JTAG_W]);
	assign div_n_s = sync_raw[cmcc_pkg::DIV_W+1:2];
	assign en_s = sync_raw[1];
	assign pin_in_s = sync_raw[0];

	// Config writes fill the cells; user passes read them (see R5)
	cmcc_cell_mem u_mem (
		.clk_i(CORE_CLK_I),
		.wr_i(cfg_wr),
		.waddr_i(CFG_BUS_I.addr),
		.wdata_i(CFG_BUS_I.data),
		.rd_i(tick),
		.raddr_i(scan_addr_q),
		.rdata_o(rdata)
	);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			cmcc_pkg::ST_CONFIG:
			begin
				if (frame_bad)
				begin
					state_d = cmcc_pkg::ST_FAULT;
				end
				else if (CFG_BUS_I.done)
				begin
					state_d = cmcc_pkg::ST_USER;
				end
			end
			cmcc_pkg::ST_USER: state_d = cmcc_pkg::ST_USER;
			cmcc_pkg::ST_FAULT: state_d = cmcc_pkg::ST_FAULT;
			default: state_d = cmcc_pkg::ST_FAULT;
		endcase
	end

	// Frame CRC during configuration
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= cmcc_pkg::ST_CONFIG;
			crc16_q <= cmcc_pkg::CRC16_INIT;
			status_n_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			crc16_q <= frame_check ? cmcc_pkg::CRC16_INIT : crc16_next; // see (R6)
			if (frame_bad)
			begin
				status_n_q <= 1'b0; // see (R7)
			end
		end
	end

	// Rate divider for the background pass
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt_q <= '0;
		end
		else
		begin
			div_cnt_q <= (tick || !running) ? '0 : div_cnt_q + cmcc_pkg::DIVCNT_ONE; // see (R17)
		end
	end

	// Background pass over all cells
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scan_addr_q <= cmcc_pkg::ADDR_FIRST;
			rd_pend_q <= 1'b0;
			last_pend_q <= 1'b0;
			pass_done_q <= 1'b0;
			crc_q <= cmcc_pkg::CRC32_INIT;
			signature_q <= cmcc_pkg::SIG_ZERO;
			fail_q <= 1'b0;
		end
		else
		begin
			rd_pend_q <= tick;
			last_pend_q <= tick && (scan_addr_q == cmcc_pkg::ADDR_LAST);
			pass_done_q <= rd_pend_q && last_pend_q;
			if (tick)
			begin
				scan_addr_q <= scan_addr_q + cmcc_pkg::ADDR_STEP; // see (R18)
			end
			if (rd_pend_q && last_pend_q)
			begin
				crc_q <= cmcc_pkg::CRC32_INIT; // see (R4)
				signature_q <= sig_next; // see (R8) (R11)
				fail_q <= (sig_next != cmcc_pkg::SIG_ZERO); // see (R9) (R16)
			end
			else if (rd_pend_q)
			begin
				crc_q <= crc_word; // see (R15)
			end
		end
	end

	// Storage register: load at configuration end, scan chain under the instruction
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			store_q <= cmcc_pkg::SIG_ZERO;
			tck_prev_q <= 1'b0;
			tdo_q <= 1'b0;
		end
		else
		begin
			tck_prev_q <= jtag_s.tck;
			if (cfg_finish)
			begin
				store_q <= CFG_BUS_I.final_crc; // see (R10)
			end
			else if (shift_hit)
			begin
				store_q <= {jtag_s.tdi, store_q[31:1]}; // see (R12) (R14)
			end
			tdo_q <= instr_active ? store_q[0] : 1'b0; // see (R14)
		end
	end

	// Dual-purpose pin drive
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			err_pin_q <= 1'b0;
			err_oe_n_q <= 1'b1;
		end
		else
		begin
			err_pin_q <= en_s ? fail_q : USER_OUT_I; // see (R1) (R2) (R3)
			err_oe_n_q <= en_s ? 1'b0 : USER_OE_N_I; // see (R2) (R3)
		end
	end

	assign ERR_PIN_O = err_pin_q;
	assign ERR_PIN_OE_N_O = err_oe_n_q;
	assign USER_IN_O = pin_in_s;
	assign CONFIG_STATUS_LOW_N_O = status_n_q;
	assign TDO_O = tdo_q;
	assign USER_MODE_O = state_q[0];
	assign PASS_DONE_O = pass_done_q;
	assign SIGNATURE_O = signature_q;

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!rst_n);

	sequence s_bad_frame;
		frame_bad;
	endsequence

	sequence s_status_held;
		!CONFIG_STATUS_LOW_N_O [*4];
	endsequence

	sequence s_pass_end;
		rd_pend_q && last_pend_q;
	endsequence

	a_pin_enabled_drive: assert property (en_s |=> (!ERR_PIN_OE_N_O && ERR_PIN_O == $past(fail_q))) // see (R1) (R3)
		else $error("failure pin not driven from fail flag");
	a_pin_user_io: assert property (!en_s |=> (ERR_PIN_O == $past(USER_OUT_I))) // see (R2)
		else $error("pin not returned to user I/O");
	a_sig_nonzero_fail: assert property (pass_done_q |-> (fail_q == (signature_q != cmcc_pkg::SIG_ZERO))) // see (R8) (R9)
		else $error("fail flag disagrees with signature");
	a_fail_held: assert property (!(rd_pend_q && last_pend_q) |=> $stable(fail_q)) // see (R16)
		else $error("fail flag changed mid pass");
	a_pass_restart: assert property (s_pass_end |-> (scan_addr_q == cmcc_pkg::ADDR_FIRST) ##1 (crc_q == cmcc_pkg::CRC32_INIT)) // see (R4) (R18)
		else $error("pass did not restart");
	a_status_low: assert property (s_bad_frame |=> s_status_held) // see (R7)
		else $error("status line not held low");
	a_store_load: assert property (cfg_finish |=> store_q == $past(CFG_BUS_I.final_crc)) // see (R10)
		else $error("storage register not loaded");
	a_scan_shift: assert property (shift_hit |=> store_q == {$past(jtag_s.tdi), $past(store_q[31:1])}) // see (R12)
		else $error("scan chain shift wrong");
	a_scan_no_halt: assert property (running && instr_active |-> ##[0:256] tick) // see (R13) (R17)
		else $error("checker halted during scan");
	a_sig_held: assert property (!(rd_pend_q && last_pend_q) |=> $stable(signature_q)) // see (R8) (R16)
		else $error("signature changed mid pass");
	a_tdo_idle: assert property (!instr_active |=> !TDO_O) // see (R14)
		else $error("scan output active without instruction");
endmodule // cmcc_top

/* File: test/cmcc_tester.sv */
// Far-side model: scan tester shifting the storage chain, and the board pad.
// Assumes calls start at a falling edge of the core clock.
`timescale 1ns/10ps
module cmcc_tester (
	input wire logic clk_i,
	input wire logic tdo_i,
	input wire logic pin_o_i,
	input wire logic pin_oe_n_i,
	output cmcc_pkg::cmcc_jtag_s jtag_o,
	output wire logic pad_o
);
	// Board pull-down when the pad is not driven
	assign pad_o = (pin_oe_n_i == 1'b0) ? pin_o_i : 1'b0;
	initial jtag_o = '0;
	// Capture TDO, then shift one bit per tck rise, LSB first
	task automatic shift(input logic [9:0] ir, input logic [31:0] v, output logic [31:0] got);
		jtag_o.ir = ir;
		jtag_o.shift_dr = 1'b1;
		for (int i = 0; i < 32; i++)
		begin
			jtag_o.tdi = v[i];
			repeat (4) @(negedge clk_i);
			got[i] = tdo_i;
			jtag_o.tck = 1'b1;
			repeat (4) @(negedge clk_i);
			jtag_o.tck = 1'b0;
		end
		jtag_o.shift_dr = 1'b0;
		jtag_o.tdi = ~jtag_o.tdi;
		@(negedge clk_i);
	endtask
endmodule // cmcc_tester

/* File: test/cmcc_top_bench.sv */
// Self-checking bench for the configuration memory CRC checker.
// Assumes the tester model on the scan inputs and a pulled-down pad.
`timescale 1ns/10ps
module cmcc_top_bench;
	logic clk;
	logic nrst;
	logic en;
	logic [3:0] divn;
	cmcc_pkg::cmcc_cfg_s cfg;
	cmcc_pkg::cmcc_jtag_s jtag;
	logic uout;
	logic uoe_n;
	wire pad;
	logic err_o, oe_n, uin, stat_n, tdo, umode, pdone;
	logic [31:0] sig;
	logic [31:0] mem [64];
	logic [31:0] gold;
	logic [31:0] got;
	int n;
	int err_total;
	int tests_run;

	cmcc_top dut_u (.CORE_CLK_I(clk), .NRST_I(nrst), .ENABLE_I(en), .DIV_N_I(divn),
		.CFG_BUS_I(cfg), .JTAG_I(jtag), .USER_OUT_I(uout), .USER_OE_N_I(uoe_n),
		.ERR_PIN_I(pad), .ERR_PIN_O(err_o), .ERR_PIN_OE_N_O(oe_n), .USER_IN_O(uin),
		.CONFIG_STATUS_LOW_N_O(stat_n), .TDO_O(tdo), .USER_MODE_O(umode),
		.PASS_DONE_O(pdone), .SIGNATURE_O(sig));
	cmcc_tester tester_u (.clk_i(clk), .tdo_i(tdo), .pin_o_i(err_o), .pin_oe_n_i(oe_n),
		.jtag_o(jtag), .pad_o(pad));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] crc_w(input logic [31:0] c, input logic [31:0] d,
		input logic [31:0] p, input int w);
		for (int i = 31; i >= 0; i--)
		begin
			c = (c[w-1] ^ d[i]) ? ((c << 1) ^ p) : (c << 1);
		end
		return c;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic wait_pass();
		n = 0;
		while (pdone !== 1'b1 && n < 2000)
		begin
			tick(1);
			n++;
		end
		chk(pdone, 1, "pass end missing");
	endtask

	task automatic do_reset();
		nrst = 1'b0;
		tick(3);
		chk({err_o, oe_n, stat_n, tdo, umode, pdone}, 32'h18, "reset outputs");
		chk(sig, 0, "reset signature");
		nrst = 1'b1;
		tick(6);
	endtask

	task automatic t_disabled();
		uout = 1'b1;
		uoe_n = 1'b0;
		tick(4);
		chk({err_o, oe_n, uin}, 32'h5, "user pin drive");
		uoe_n = 1'b1;
		tick(4);
		chk({oe_n, uin}, 32'h2, "user pin released");
		en = 1'b1;
		tick(4);
	endtask

	task automatic t_config(input logic bad);
		logic [15:0] c16;
		cmcc_pkg::cmcc_cfg_s req;
		c16 = cmcc_pkg::CRC16_INIT;
		for (int k = 0; k < 64; k++)
		begin
			c16 = 16'(crc_w({16'h0000, c16}, mem[k], {16'h0000, cmcc_pkg::CRC16_POLY}, 16));
			req = '0;
			req.wr = 1'b1;
			req.addr = k[5:0];
			req.data = mem[k];
			if (k % 16 == 15)
			begin
				req.frame_end = 1'b1;
				req.frame_crc = c16 ^ {15'h0000, bad && k == 15};
				c16 = cmcc_pkg::CRC16_INIT;
			end
			cfg = req;
			tick(1);
		end
		cfg = '0;
		tick(2);
		chk(stat_n, !bad, "frame check status");
		req = '0;
		req.done = 1'b1;
		req.final_crc = gold;
		cfg = req;
		tick(1);
		cfg = '0;
		tick(2);
		chk(umode, !bad, "user mode entry");
	endtask

	task automatic t_clean();
		wait_pass();
		tick(1);
		wait_pass();
		chk(sig, 0, "clean signature");
		chk({err_o, oe_n}, 0, "clean pin");
		tick(1);
	endtask

	task automatic t_divider(input logic [3:0] d);
		divn = d;
		for (int r = 0; r < 3; r++)
		begin
			wait_pass();
			tick(1);
		end
		wait_pass();
		chk(n + 1, 64 << d, "pass period");
		tick(1);
	endtask

	task automatic t_inject();
		tester_u.shift(10'h000, gold ^ 32'h1, got);
		chk(got, 0, "scan refused under other code");
		tester_u.shift(10'h015, gold ^ 32'h1, got);
		chk(got, gold, "stored value read out");
		wait_pass();
		tick(1);
		wait_pass();
		chk(sig, 1, "injected signature");
		chk({err_o, umode}, 3, "injected error pin");
		tick(30);
		chk(err_o, 1, "pin held mid pass");
		tick(1);
		wait_pass();
		chk(sig, 1, "still calculating");
		tester_u.shift(10'h015, gold, got);
		chk(got, gold ^ 32'h1, "injected value read out");
		tick(1);
		wait_pass();
		tick(1);
		wait_pass();
		chk(sig, 0, "clean after restore");
		chk(err_o, 0, "pin low after restore");
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#5000000;
		err_total++;
		give_verdict();
	end

	initial
	begin
		nrst = 1'b0;
		en = 1'b0;
		divn = 4'h0;
		cfg = '0;
		uout = 1'b0;
		uoe_n = 1'b1;
		err_total = 0;
		tests_run = 0;
		gold = cmcc_pkg::CRC32_INIT;
		for (int k = 0; k < 64; k++)
		begin
			mem[k] = (k + 1) * 32'h9e3779b1;
			gold = crc_w(gold, mem[k], cmcc_pkg::CRC32_POLY, 32);
		end
		do_reset();
		t_disabled();
		t_config(1'b0);
		t_clean();
		t_divider(4'h1);
		t_divider(4'h3);
		t_divider(4'h0);
		t_inject();
		do_reset();
		t_config(1'b1);
		give_verdict();
	end
endmodule // cmcc_top_bench
